// *** core/tdcf_regs.svh ***
// register offsets, field positions, reset values and timing of the event formatter
// assumes inclusion by bare name from the formatter and its package users
`ifndef TDCF_REGS_SVH
`define TDCF_REGS_SVH
`define TDCF_OFS_BUF_END 16'h1000
`define TDCF_OFS_CTRL 16'h1000
`define TDCF_OFS_STAT 16'h1002
`define TDCF_OFS_AFL 16'h1022
`define TDCF_OFS_TEST 16'h1028
`define TDCF_OFS_IDXQ 16'h1038
`define TDCF_CTRL_RST 16'h0020
`define TDCF_AFL_RST 16'h0040
`define TDCF_FULL_MARGIN 33
`define TDCF_IDXQ_DEPTH 4
`define TDCF_C_BERR 0
`define TDCF_C_TON 1
`define TDCF_C_TSRC 2
`define TDCF_C_BLANK 3
`define TDCF_C_PAD 4
`define TDCF_C_INL 5
`define TDCF_C_TEST 6
`define TDCF_C_IDXQ 8
`define TDCF_C_LONG 9
`define TDCF_S_FULL 2
`define TDCF_S_BFAULT 10
`define TDCF_S_TLOST 15
`define TDCF_TY_GHDR 5'h08
`define TDCF_TY_GTRL 5'h10
`define TDCF_TY_TAG 5'h11
`define TDCF_TY_FILL 5'h18
`define TDCF_SUB_HDR 3'h1
`define TDCF_SUB_MEAS 3'h0
`define TDCF_SUB_ERR 3'h4
`define TDCF_SUB_TRL 3'h3
`define TDCF_TAG_STEP_NS 800
`define TDCF_CLK_NS 50
`endif

// *** core/tdcf_pkg.sv ***
// types shared by the event formatter and its environment
// assumes nothing beyond a SystemVerilog compiler
package tdcf_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DATA, ST_TAG, ST_TRL, ST_PAD} tdcf_state_t;
  // one word offered by the converter chips, plus end-of-trigger pulse
  typedef struct packed {
    logic valid;
    logic fin;
    logic [2:0] sub;
    logic [26:0] payload;
  } tdcf_chip_t;
  // one register access, single-cycle strobes
  typedef struct packed {
    logic rd;
    logic wr;
    logic blk;
    logic blk64;
    logic [15:0] addr;
    logic [31:0] wdata;
  } tdcf_req_t;
  typedef struct packed {
    logic ack;
    logic berr;
    logic [31:0] rdata;
  } tdcf_rsp_t;
  // complete state of the formatter except the buffer storage
  typedef struct packed {
    tdcf_state_t st;
    logic [15:0] ctrl;
    logic [15:0] afl;
    logic [15:0] stat;
    logic bfault;
    logic tlost;
    logic [21:0] evt;
    logic [15:0] wc;
    logic errsn;
    logic fin;
    logic rdy;
    logic [26:0] tag;
    logic [26:0] tagl;
    logic [7:0] pre;
    logic [1:0] skn;
    logic [31:0] sk0;
    logic [31:0] sk1;
    logic [14:0] wptr;
    logic [14:0] rptr;
    logic [15:0] cnt;
    logic [15:0] evn;
    logic [3:0][31:0] iq;
    logic [2:0] iqn;
    logic par;
    logic s1;
    logic s2;
    logic s3;
    logic termf;
    logic term;
    tdcf_rsp_t rsp;
  } tdcf_st_t;
endpackage

// *** core/tdcf_formatter.sv ***
// event formatter: frames chip data into readout buffer words, holds control and status
// assumes chip stream, triggers and register strobes on clk; resistor switch pin is asynchronous
//
// Summary of operation
// RL1: each trigger moves enabled hits into one event; triggers arriving while a frame is open are dropped
// RL2: event opens with header: slot, 22-bit count
// RL3: per chip: header, measurements, errors, trailer
// RL4: optional time tag, 800 ns steps
// RL5: event closes with trailer: slot, words, status
// RL6: bits 31..27 give the word type
// RL7: bits 29..27 give chip data subtype
// RL8: error words carry group and chip flags
// RL9: filler words answer reads of empty buffer
// RL10: 64-bit blocks get one filler when odd
// RL11: bus error only when enabled, else acknowledge
// RL12: resistors follow software bit when source set
// RL13: blank frames written only when enabled
// RL14: odd events padded with filler when enabled
// RL15: inl correction follows its control bit
// RL16: buffer test mode follows its control bit
// RL17: index queue gets count and words per event
// RL18: time tag present only while long_stamp_on
// RL19: frames_available by events or by data
// RL20: near-limit by threshold, full at depth-33
// RL21: status reports bin_size_select code
// RL22: fault and dropped flags clear on read
// RL23: test mode injects host words, blocks chips
// RL24: fill threshold resets to 64 words
// RL25: occupancy status recomputed every clock
`timescale 1ns/1ps
`include "tdcf_regs.svh"
module tdcf_formatter #(
  parameter int DEPTH = 32768,
  parameter logic [4:0] SLOT_ID = 5'h1F
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sw_clear,
  input wire logic trig,
  input wire logic cnt_reset,
  input wire logic windowed_capture_mode,
  input wire logic chip_hdr_on,
  input wire logic chip_err_on,
  input wire logic [3:0] chip_fault,
  input wire logic [1:0] bin_size_select,
  input wire logic pair_mode,
  input wire logic term_switch_pin,
  input wire tdcf_pkg::tdcf_chip_t chip,
  output logic chip_ready,
  input wire tdcf_pkg::tdcf_req_t req,
  output tdcf_pkg::tdcf_rsp_t rsp,
  output logic bus_end_resistors_on,
  output logic inl_correction_on,
  output logic buffer_selftest_on
);
  localparam int AW = $clog2(DEPTH);
  localparam int TAG_CYC = (`TDCF_TAG_STEP_NS + `TDCF_CLK_NS - 1) / `TDCF_CLK_NS;
  localparam logic [15:0] FULL_LVL = 16'(DEPTH - `TDCF_FULL_MARGIN);
  localparam logic [15:0] DEPTH_W = 16'(DEPTH);

  initial begin
    if (DEPTH < 64 || DEPTH > 32768 || TAG_CYC > 256) begin
      $error("tdcf_formatter: unsupported DEPTH or tag step");
    end
  end

  tdcf_pkg::tdcf_st_t s;
  tdcf_pkg::tdcf_st_t n;
  logic [31:0] mem [DEPTH];
  logic [31:0] head;
  logic wr_en;
  logic fpush;
  logic [31:0] fw;
  logic tpush;
  logic room;
  logic [1:0] skp;
  logic keep;
  logic [15:0] wnext;
  logic rd_buf;

  assign head = mem[s.rptr[AW-1:0]];

  always_comb begin
    n = s;
    fpush = 1'b0;
    fw = 32'h0;
    tpush = 1'b0;
    keep = 1'b0;
    wnext = s.wc + 16'h0001;
    rd_buf = req.rd && (req.addr < `TDCF_OFS_BUF_END);
    // switch pin: three stages, level taken when last two agree
    n.s1 = term_switch_pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (s.s2 == s.s3) begin
      n.termf = s.s3;
    end
    // RL12: resistor source select
    n.term = s.ctrl[`TDCF_C_TSRC] ? s.ctrl[`TDCF_C_TON] : s.termf;
    // RL4: arrival-time counter in 800 ns steps
    if (cnt_reset) begin
      n.pre = 8'h00;
      n.tag = 27'h0;
    end else if (s.pre == 8'(TAG_CYC - 1)) begin
      n.pre = 8'h00;
      n.tag = s.tag + 27'h1;
    end else begin
      n.pre = s.pre + 8'h01;
    end
    // skid drain into the buffer, stalls while the buffer is full
    wr_en = (s.skn != 2'd0) && (s.cnt < DEPTH_W);
    skp = s.skn - {1'b0, wr_en};
    room = (skp != 2'd2);
    if (wr_en) begin
      n.sk0 = s.sk1;
      n.wptr = (s.wptr == 15'(DEPTH - 1)) ? 15'h0 : s.wptr + 15'h1;
    end
    // register answers, one cycle after the strobe
    n.rsp = '0;
    if (!req.blk) begin
      n.par = 1'b0;
    end
    if (rd_buf) begin
      if (s.cnt != 16'h0) begin
        n.rsp.ack = 1'b1;
        n.rsp.rdata = head;
        n.par = ~s.par;
        n.rptr = (s.rptr == 15'(DEPTH - 1)) ? 15'h0 : s.rptr + 15'h1;
      end else if (s.ctrl[`TDCF_C_BERR] && req.blk && req.blk64 && s.par) begin
        // RL10: even out a 64-bit block with one filler
        n.rsp.ack = 1'b1;
        n.rsp.rdata = {`TDCF_TY_FILL, 27'h0};
        n.par = 1'b0;
      end else if (s.ctrl[`TDCF_C_BERR]) begin
        // RL11: empty read ends with a bus error
        n.rsp.berr = 1'b1;
      end else begin
        // RL9: filler for an empty buffer
        n.rsp.ack = 1'b1;
        n.rsp.rdata = {`TDCF_TY_FILL, 27'h0};
      end
    end else if (req.rd) begin
      n.rsp.ack = 1'b1;
      unique case (req.addr)
        `TDCF_OFS_CTRL: n.rsp.rdata = {16'h0, s.ctrl};
        `TDCF_OFS_STAT: begin
          n.rsp.rdata = {16'h0, s.stat};
          // RL22: status read clears both sticky flags
          n.bfault = 1'b0;
          n.tlost = 1'b0;
        end
        `TDCF_OFS_AFL: n.rsp.rdata = {16'h0, s.afl};
        `TDCF_OFS_IDXQ: begin
          n.rsp.rdata = s.iq[0];
          if (s.iqn != 3'd0) begin
            n.iq = {32'h0, s.iq[3:1]};
            n.iqn = s.iqn - 3'd1;
          end
        end
        default: n.rsp.rdata = 32'h0;
      endcase
    end else if (req.wr) begin
      n.rsp.ack = 1'b1;
      unique case (req.addr)
        `TDCF_OFS_CTRL: n.ctrl = req.wdata[15:0];
        `TDCF_OFS_AFL: n.afl = req.wdata[15:0];
        `TDCF_OFS_TEST: tpush = s.ctrl[`TDCF_C_TEST];
        default: n.afl = s.afl;
      endcase
    end
    // RL22: hardware set wins over the read clear
    if (rd_buf && s.cnt == 16'h0 && s.ctrl[`TDCF_C_BERR] && !(req.blk && req.blk64 && s.par)) begin
      n.bfault = 1'b1;
    end
    if (trig && windowed_capture_mode && s.st != tdcf_pkg::ST_IDLE) begin
      n.tlost = 1'b1;
    end
    // formatter sequence
    unique case (s.st)
      tdcf_pkg::ST_IDLE: begin
        if (s.ctrl[`TDCF_C_TEST]) begin
          // RL23: chip words accepted and dropped in test mode
          fpush = 1'b0;
        end else if (windowed_capture_mode) begin
          // RL1: trigger opens a frame
          if (trig) begin
            n.st = tdcf_pkg::ST_WAIT;
            n.tagl = s.tag;
            n.wc = 16'h0;
            n.errsn = 1'b0;
            n.fin = 1'b0;
          end
        end else if (chip.valid && s.rdy) begin
          // continuous mode stores every chip word as it comes
          fpush = 1'b1;
          fw = {2'b00, chip.sub, chip.payload};
        end
      end
      tdcf_pkg::ST_WAIT: begin
        if (chip.fin) begin
          n.fin = 1'b1;
        end
        if (chip.valid || ((chip.fin || s.fin) && s.ctrl[`TDCF_C_BLANK])) begin
          // RL2: global header ahead of any chip word
          if (room) begin
            fpush = 1'b1;
            // RL6: type code in the top five bits
            fw = {`TDCF_TY_GHDR, s.evt, SLOT_ID};
            n.wc = 16'h1;
            n.st = tdcf_pkg::ST_DATA;
          end
        end else if (chip.fin || s.fin) begin
          // RL13: empty trigger leaves nothing behind
          n.evt = s.evt + 22'h1;
          n.st = tdcf_pkg::ST_IDLE;
        end
      end
      tdcf_pkg::ST_DATA: begin
        if (chip.fin) begin
          n.fin = 1'b1;
        end
        if (chip.valid && s.rdy) begin
          // RL3: chip headers and trailers, errors kept when enabled
          unique case (chip.sub)
            `TDCF_SUB_HDR, `TDCF_SUB_TRL: keep = chip_hdr_on;
            `TDCF_SUB_ERR: keep = chip_err_on;
            default: keep = 1'b1;
          endcase
          // RL7: subtype below a 00 type prefix; RL8: error flags pass untouched
          fpush = keep;
          fw = {2'b00, chip.sub, chip.payload};
          if (keep) begin
            n.wc = wnext;
          end
          if (keep && chip.sub == `TDCF_SUB_ERR) begin
            n.errsn = 1'b1;
          end
        end else if (s.fin) begin
          // RL18: time tag only with long_stamp_on
          n.st = s.ctrl[`TDCF_C_LONG] ? tdcf_pkg::ST_TAG : tdcf_pkg::ST_TRL;
        end
      end
      tdcf_pkg::ST_TAG: begin
        if (room) begin
          // RL4: latched arrival time
          fpush = 1'b1;
          fw = {`TDCF_TY_TAG, s.tagl};
          n.wc = wnext;
          n.st = tdcf_pkg::ST_TRL;
        end
      end
      tdcf_pkg::ST_TRL: begin
        if (room) begin
          // RL5: trailer with word count and status
          fpush = 1'b1;
          fw = {`TDCF_TY_GTRL, 2'b00, s.errsn, 3'b000, wnext, SLOT_ID};
          n.evt = s.evt + 22'h1;
          // RL17: index word per stored event
          if (s.ctrl[`TDCF_C_IDXQ] && s.iqn != 3'(`TDCF_IDXQ_DEPTH)) begin
            n.iq[n.iqn[1:0]] = {s.evt[15:0], wnext};
            n.iqn = n.iqn + 3'd1;
          end
          // RL14: odd events padded when enabled
          n.st = (s.ctrl[`TDCF_C_PAD] && wnext[0]) ? tdcf_pkg::ST_PAD : tdcf_pkg::ST_IDLE;
        end
      end
      tdcf_pkg::ST_PAD: begin
        if (room) begin
          fpush = 1'b1;
          fw = {`TDCF_TY_FILL, 27'h0};
          n.st = tdcf_pkg::ST_IDLE;
        end
      end
    endcase
    // skid fill, formatter first, injected host word otherwise
    n.skn = skp;
    if (fpush || (tpush && room)) begin
      if (skp == 2'd0) begin
        n.sk0 = fpush ? fw : req.wdata;
      end else begin
        n.sk1 = fpush ? fw : req.wdata;
      end
      n.skn = skp + 2'd1;
    end
    // buffer occupancy in words and complete events
    n.cnt = s.cnt + {15'h0, wr_en} - {15'h0, rd_buf && s.cnt != 16'h0};
    n.evn = s.evn + {15'h0, wr_en && s.sk0[31:27] == `TDCF_TY_GTRL}
      - {15'h0, rd_buf && s.cnt != 16'h0 && head[31:27] == `TDCF_TY_GTRL};
    // RL25: status rebuilt every clock; RL19 RL20 RL21 fields
    n.stat = {s.tlost, pair_mode, bin_size_select, s.cnt == 16'h0, s.bfault, chip_fault, s.term,
      chip_hdr_on, windowed_capture_mode, s.cnt >= FULL_LVL, s.cnt >= s.afl,
      windowed_capture_mode ? s.evn != 16'h0 : s.cnt != 16'h0};
    // ready only with an empty skid so an accepted word always fits, or while idle in test mode where words are dropped
    n.rdy = (n.skn == 2'd0) && (n.st == tdcf_pkg::ST_DATA || n.st == tdcf_pkg::ST_IDLE && !windowed_capture_mode);
    if (n.ctrl[`TDCF_C_TEST] && n.st == tdcf_pkg::ST_IDLE) begin
      n.rdy = 1'b1;
    end
    if (sw_clear) begin
      n.st = tdcf_pkg::ST_IDLE;
      n.skn = 2'd0;
      n.wptr = 15'h0;
      n.rptr = 15'h0;
      n.cnt = 16'h0;
      n.evn = 16'h0;
      n.evt = 22'h0;
      n.iqn = 3'd0;
      n.rdy = 1'b0;
    end
  end

  // state register; RL24 and RL15 RL16 reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.st <= tdcf_pkg::ST_IDLE;
      s.ctrl <= `TDCF_CTRL_RST;
      s.afl <= `TDCF_AFL_RST;
    end else begin
      s <= n;
    end
  end

  // buffer storage
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[s.wptr[AW-1:0]] <= s.sk0;
    end
  end

  assign chip_ready = s.rdy;
  assign rsp = s.rsp;
  assign bus_end_resistors_on = s.term;
  // RL15: inl correction bit out
  assign inl_correction_on = s.ctrl[`TDCF_C_INL];
  // RL16: test mode bit out
  assign buffer_selftest_on = s.ctrl[`TDCF_C_TEST];

  sequence s_hdr_push;
    s.st == tdcf_pkg::ST_WAIT && fpush;
  endsequence
  sequence s_trl_push;
    s.st == tdcf_pkg::ST_TRL && fpush;
  endsequence

  a_hdr_word: assert property (@(posedge clk) disable iff (reset) // RL2
    s_hdr_push |-> fw[31:27] == `TDCF_TY_GHDR && fw[26:5] == s.evt && fw[4:0] == SLOT_ID)
    else $error("global header malformed");
  a_trl_count: assert property (@(posedge clk) disable iff (reset || sw_clear) // RL5
    s_trl_push |-> fw[31:27] == `TDCF_TY_GTRL && fw[20:5] == s.wc + 16'h1 ##1 s.evt == $past(s.evt) + 22'h1)
    else $error("trailer type or count wrong");
  a_tag_gate: assert property (@(posedge clk) disable iff (reset || sw_clear) // RL18
    s.st == tdcf_pkg::ST_DATA && s.fin && !(chip.valid && s.rdy) |=> s.st == ($past(s.ctrl[`TDCF_C_LONG])
      ? tdcf_pkg::ST_TAG : tdcf_pkg::ST_TRL))
    else $error("time tag gating wrong");
  a_fill_empty: assert property (@(posedge clk) disable iff (reset) // RL9
    rd_buf && s.cnt == 16'h0 && !s.ctrl[`TDCF_C_BERR] |=> rsp.ack && !rsp.berr
      && rsp.rdata == {`TDCF_TY_FILL, 27'h0})
    else $error("empty read not answered with filler");
  a_berr_empty: assert property (@(posedge clk) disable iff (reset) // RL11
    rd_buf && s.cnt == 16'h0 && s.ctrl[`TDCF_C_BERR] && !req.blk |=> rsp.berr && !rsp.ack && s.bfault)
    else $error("empty read with bus error enabled not refused");
  a_blank_skip: assert property (@(posedge clk) disable iff (reset || sw_clear) // RL13
    s.st == tdcf_pkg::ST_WAIT && !chip.valid && (chip.fin || s.fin) && !s.ctrl[`TDCF_C_BLANK]
      |-> !fpush ##1 s.st == tdcf_pkg::ST_IDLE)
    else $error("blank trigger wrote words");
  a_term_follow: assert property (@(posedge clk) disable iff (reset) // RL12
    s.ctrl[`TDCF_C_TSRC] && $stable(s.ctrl) |=> bus_end_resistors_on == $past(s.ctrl[`TDCF_C_TON]))
    else $error("resistors ignore software bit");
  a_full_flag: assert property (@(posedge clk) disable iff (reset) // RL20
    ##1 s.stat[`TDCF_S_FULL] == ($past(s.cnt) >= FULL_LVL))
    else $error("full flag wrong");
  a_clr_read: assert property (@(posedge clk) disable iff (reset) // RL22
    req.rd && req.addr == `TDCF_OFS_STAT && !(trig && s.st != tdcf_pkg::ST_IDLE) |=> !s.tlost)
    else $error("dropped trigger flag not cleared by read");
  a_test_keep: assert property (@(posedge clk) disable iff (reset) // RL23
    s.ctrl[`TDCF_C_TEST] && s.st == tdcf_pkg::ST_IDLE |-> !fpush)
    else $error("chip data entered buffer in test mode");
endmodule

// *** tb/tdcf_host_model.sv ***
// bus master model: single register and buffer accesses towards the formatter
// assumes strobes are taken on the rising clk edge and answered one cycle later
`timescale 1ns/1ps
module tdcf_host_model (
  input wire logic clk,
  output tdcf_pkg::tdcf_req_t req,
  input wire tdcf_pkg::tdcf_rsp_t rsp
);
  // idle bus, no block transfer
  initial begin
    req = '0;
    req.addr = 16'hFFFF;
  end
  // block transfer levels, changed only between accesses
  task automatic block(input logic on, input logic wide);
    @(posedge clk);
    #1;
    req.blk = on;
    req.blk64 = wide;
  endtask
  // one strobe cycle, answer taken once the next edge has landed
  task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                        output tdcf_pkg::tdcf_rsp_t got);
    @(posedge clk);
    #1;
    req.rd = ~wr;
    req.wr = wr;
    req.addr = addr;
    req.wdata = wdata;
    @(posedge clk);
    #1;
    got = rsp;
    req.rd = 1'b0;
    req.wr = 1'b0;
    // released lines scrambled so stale values never look valid
    req.addr = ~addr;
    req.wdata = ~wdata;
  endtask
endmodule

// *** tb/tdc_event_output_formatter_tb_top.sv ***
// self-checking bench for the event formatter: framing, fillers, control and status
// assumes the host model above and a design built with a 64-word buffer
`timescale 1ns/1ps
`include "tdcf_regs.svh"
module tdc_event_output_formatter_tb_top;
  localparam logic [4:0] SLOT = 5'h1F;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sw_clear = 1'b0, trig = 1'b0, cnt_reset = 1'b0, mode = 1'b1, pin = 1'b0;
  logic hdr_on = 1'b1, err_on = 1'b1;
  tdcf_pkg::tdcf_chip_t chip = '0;
  tdcf_pkg::tdcf_req_t req;
  tdcf_pkg::tdcf_rsp_t rsp;
  tdcf_pkg::tdcf_rsp_t r;
  logic chip_ready, res_on, inl_on, test_on;
  logic [31:0] w;
  logic [31:0] b [0:3];
  int fails = 0;
  int n_tests = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  tdcf_formatter #(.DEPTH(64), .SLOT_ID(SLOT)) dut (
    .clk(clk), .reset(reset), .sw_clear(sw_clear), .trig(trig), .cnt_reset(cnt_reset),
    .windowed_capture_mode(mode), .chip_hdr_on(hdr_on), .chip_err_on(err_on), .chip_fault(4'h5),
    .bin_size_select(2'h2), .pair_mode(1'b1), .term_switch_pin(pin), .chip(chip),
    .chip_ready(chip_ready), .req(req), .rsp(rsp), .bus_end_resistors_on(res_on),
    .inl_correction_on(inl_on), .buffer_selftest_on(test_on)
  );
  tdcf_host_model host (.clk(clk), .req(req), .rsp(rsp));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, r);
    chk({31'h0, r.ack}, 32'h0000_0001);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    host.access(1'b0, a, 32'h0000_0000, r);
    d = r.rdata;
  endtask
  task automatic rdn(input int n);
    for (int k = 0; k < n; k++) rd(16'h0000, b[k]);
  endtask
  // expected global trailer with the status field masked out
  function automatic logic [31:0] trl(input logic [15:0] wc);
    return {5'h10, 6'h00, wc, SLOT};
  endfunction
  // chip word held until taken; valid left up for a following word
  task automatic offer(input logic [29:0] d);
    int g;
    g = 0;
    chip.valid = 1'b1;
    {chip.sub, chip.payload} = d;
    while (chip_ready !== 1'b1 && g < 50) begin
      tick(1);
      g++;
    end
    chk({31'h0, chip_ready}, 32'h0000_0001);
    tick(1);
  endtask
  // trigger (twice when dbl), n words, end pulse, then time to close the event
  task automatic event_run(input int n, input logic dbl, input logic [29:0] w0, input logic [29:0] w1);
    trig = 1'b1;
    tick(dbl ? 2 : 1);
    trig = 1'b0;
    for (int k = 0; k < n; k++) offer(k == 0 ? w0 : w1);
    chip.valid = 1'b0;
    chip.payload = ~chip.payload;
    tick(1);
    chip.fin = 1'b1;
    tick(1);
    chip.fin = 1'b0;
    tick(12);
  endtask
  task automatic finish_test;
    $display("Checks made: %0d, mismatches: %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    #2_000_000;
    fails++;
    finish_test;
  end

  // main sequence
  initial begin
    tick(10);
    reset = 1'b0;
    tick(3);
    rd(`TDCF_OFS_CTRL, w);
    chk(w, 32'h0000_0020);
    chk({31'h0, inl_on}, 32'h0000_0001);
    rd(`TDCF_OFS_AFL, w);
    chk(w, 32'h0000_0040);
    rd(16'h0000, w);
    chk({27'h0, w[31:27]}, 32'h0000_0018);
    chk({30'h0, r.ack, r.berr}, 32'h0000_0002);
    // framed event with a measurement and an error word
    event_run(2, 1'b0, 30'h0001_2345, {3'h4, 27'h000_7000});
    rd(`TDCF_OFS_STAT, w);
    chk(w, 32'h0000_6159);
    rdn(4);
    chk(b[0] & 32'hF800_001F, 32'h4000_001F);
    chk(b[1], 32'h0001_2345);
    chk(b[2], 32'h2000_7000);
    chk(b[3] & 32'hF81F_FFFF, trl(16'h0004));
    tick(3);
    rd(`TDCF_OFS_STAT, w);
    chk(w, 32'h0000_6958);
    // bus error on empty read, sticky flag cleared by a status read
    wr(`TDCF_OFS_CTRL, 32'h0000_0021);
    rd(16'h0000, w);
    chk({30'h0, r.ack, r.berr}, 32'h0000_0001);
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[10]}, 32'h0000_0001);
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[10]}, 32'h0000_0000);
    // trigger during a frame is dropped; a blank frame writes nothing
    wr(`TDCF_OFS_CTRL, 32'h0000_0020);
    event_run(0, 1'b1, 30'h0, 30'h0);
    rd(`TDCF_OFS_STAT, w);
    chk(w & 32'h0000_8801, 32'h0000_8800);
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[15]}, 32'h0000_0000);
    // blank frame kept when enabled
    wr(`TDCF_OFS_CTRL, 32'h0000_0028);
    event_run(0, 1'b0, 30'h0, 30'h0);
    rdn(2);
    chk(b[0] & 32'hF800_001F, 32'h4000_001F);
    chk(b[1] & 32'hF81F_FFFF, trl(16'h0002));
    // chip header and error words dropped while their enables are low
    hdr_on = 1'b0;
    err_on = 1'b0;
    event_run(2, 1'b0, {3'h1, 27'h000_0ABC}, {3'h4, 27'h000_0001});
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[4]}, 32'h0000_0000);
    rdn(2);
    chk(b[0] & 32'hF800_001F, 32'h4000_001F);
    chk(b[1] & 32'hF81F_FFFF, trl(16'h0002));
    hdr_on = 1'b1;
    err_on = 1'b1;
    // odd event padded, threshold counts the pad word
    wr(`TDCF_OFS_CTRL, 32'h0000_0030);
    wr(`TDCF_OFS_AFL, 32'h0000_0004);
    event_run(1, 1'b0, 30'h0000_0ABC, 30'h0);
    rd(`TDCF_OFS_STAT, w);
    chk({30'h0, w[1:0]}, 32'h0000_0003);
    rdn(4);
    chk(b[2] & 32'hF81F_FFFF, trl(16'h0003));
    chk({27'h0, b[3][31:27]}, 32'h0000_0018);
    tick(3);
    rd(`TDCF_OFS_STAT, w);
    chk({30'h0, w[1:0]}, 32'h0000_0000);
    // time tag two 800 ns steps after count reset, plus index queue
    wr(`TDCF_OFS_CTRL, 32'h0000_0320);
    cnt_reset = 1'b1;
    tick(1);
    cnt_reset = 1'b0;
    tick(40);
    event_run(1, 1'b0, 30'h0000_0777, 30'h0);
    rdn(4);
    chk(b[2], {5'h11, 27'h000_0002});
    chk(b[3] & 32'hF81F_FFFF, trl(16'h0004));
    rd(`TDCF_OFS_IDXQ, w);
    chk({16'h0, w[15:0]}, 32'h0000_0004);
    // buffer test mode: host word enters, chip word kept out
    wr(`TDCF_OFS_CTRL, 32'h0000_0060);
    tick(2);
    chk({31'h0, test_on}, 32'h0000_0001);
    wr(`TDCF_OFS_TEST, 32'hA5A5_0F0F);
    offer(30'h0000_0111);
    chip.valid = 1'b0;
    tick(5);
    rd(16'h0000, w);
    chk(w, 32'hA5A5_0F0F);
    rd(16'h0000, w);
    chk({27'h0, w[31:27]}, 32'h0000_0018);
    // full flag at depth minus 33 words
    for (int k = 0; k < 30; k++) wr(`TDCF_OFS_TEST, k);
    tick(3);
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[2]}, 32'h0000_0000);
    wr(`TDCF_OFS_TEST, 32'h0000_001E);
    tick(3);
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[2]}, 32'h0000_0001);
    sw_clear = 1'b1;
    tick(1);
    sw_clear = 1'b0;
    // odd 64-bit block ends with one filler, then a bus error
    wr(`TDCF_OFS_CTRL, 32'h0000_0061);
    for (int k = 0; k < 3; k++) wr(`TDCF_OFS_TEST, k);
    tick(3);
    host.block(1'b1, 1'b1);
    rdn(3);
    chk(b[2], 32'h0000_0002);
    rd(16'h0000, w);
    chk({30'h0, r.ack, r.berr}, 32'h0000_0002);
    chk({27'h0, w[31:27]}, 32'h0000_0018);
    rd(16'h0000, w);
    chk({30'h0, r.ack, r.berr}, 32'h0000_0001);
    host.block(1'b0, 1'b0);
    // continuous mode stores raw words; clear empties the buffer
    wr(`TDCF_OFS_CTRL, 32'h0000_0000);
    mode = 1'b0;
    offer(30'h0000_0222);
    offer(30'h0000_0333);
    chip.valid = 1'b0;
    tick(5);
    chk({31'h0, inl_on}, 32'h0000_0000);
    rd(`TDCF_OFS_STAT, w);
    chk({31'h0, w[0]}, 32'h0000_0001);
    rd(16'h0000, w);
    chk(w, 32'h0000_0222);
    sw_clear = 1'b1;
    tick(1);
    sw_clear = 1'b0;
    tick(3);
    rd(16'h0000, w);
    chk({27'h0, w[31:27]}, 32'h0000_0018);
    mode = 1'b1;
    // termination: software bit when source set, switch pin otherwise
    wr(`TDCF_OFS_CTRL, 32'h0000_0006);
    tick(2);
    chk({31'h0, res_on}, 32'h0000_0001);
    pin = 1'b1;
    wr(`TDCF_OFS_CTRL, 32'h0000_0004);
    tick(6);
    chk({31'h0, res_on}, 32'h0000_0000);
    wr(`TDCF_OFS_CTRL, 32'h0000_0000);
    tick(6);
    chk({31'h0, res_on}, 32'h0000_0001);
    finish_test;
  end
endmodule
